// ### design/palette_port_pkg.sv
// Purpose: shared constants and carrier types for the palette host port
// Assumes: one clock mclk at 40 MHz, inputs synchronous to it
// Notes:   register-select codes follow the device register map
package palette_port_pkg;
   localparam logic [3:0] SEL_HOLD    = 4'h1;
   localparam logic [3:0] SEL_GENCTRL = 4'h8;
   localparam logic [3:0] SEL_MUXCTRL = 4'hB;
   localparam logic [7:0] MUX_PASSTHRU = 8'h2D;
   localparam int         GC_BIT_HI    = 3;
   localparam int         GC_BIT_LO    = 2;
   localparam logic [7:0] GENCTRL_RST  = 8'h00;
   localparam logic [7:0] MUXCTRL_RST  = 8'h00;
   localparam logic [7:0] VIDEO_CLOCK_OUT_DIV_RST = 8'h01;
   localparam logic [7:0] SCLK_DIV_RST = 8'h01;
   localparam int         LOW_SHIFT    = 2;

   typedef struct packed {
      logic       rdStrobe_n;
      logic       wrStrobe_n;
      logic [3:0] register_select_bus;
      logic       wideMode;
   } host_ctl_type;

   typedef enum logic [2:0] {
      SC_IDLE  = 3'b001,
      SC_RUN   = 3'b010,
      SC_EXTRA = 3'b100
   } sclk_state_type;
endpackage

// ### design/palette_host_port_shift_clock.sv
// Purpose: host strobe port, 8/6 data conversion and shift clock control
// Assumes: strobes and flags sampled on mclk; dot clock is mclk itself
// Notes:   palette RAM and full register map live outside this block
module palette_host_port_shift_clock #(
   parameter int DIV_W = 8
) (
   input  wire logic                        mclk,
   input  wire logic                        arst_n,
   input  wire palette_port_pkg::host_ctl_type hostCtl,
   input  wire logic [7:0]                  dataIn,
   output      logic [7:0]                  dataOut,
   output      logic                        dataOe,
   output      logic                        writeStrobe,
   output      logic [7:0]                  dacData,
   input  wire logic [7:0]                  holdValue,
   input  wire logic [DIV_W-1:0]            sclkDivisor,
   input  wire logic [DIV_W-1:0]            vclkDivisor,
   input  wire logic                        blank_n,
   input  wire logic                        passthrough_blank_in,
   input  wire logic                        split_nibble_flag_in,
   input  wire logic [7:0]                  pixelBus,
   input  wire logic [7:0]                  passBus,
   output      logic                        shiftClock,
   output      logic                        video_clock_out,
   output      logic                        mux_mode_indicator,
   output      logic [7:0]                  pixelOut,
   output      logic [7:0]                  generalControl
);
   logic [7:0] muxControl, next_generalControl, next_muxControl;
   logic       rdPrev, wrPrev, next_dataOe, next_writeStrobe;
   logic [7:0] next_dataOut, next_dacData;
   logic       passMode, splitEn, nibbleEn, blanking;

   // 8/6 conversion toward the DAC
   function automatic logic [7:0] toDac(input logic [7:0] d, input logic wide);
      toDac = wide ? d : (d << palette_port_pkg::LOW_SHIFT);
   endfunction

   assign passMode = (muxControl == palette_port_pkg::MUX_PASSTHRU);
   assign splitEn  = !generalControl[palette_port_pkg::GC_BIT_HI]
                   &&  generalControl[palette_port_pkg::GC_BIT_LO];
   assign nibbleEn =  generalControl[palette_port_pkg::GC_BIT_HI]
                   && !generalControl[palette_port_pkg::GC_BIT_LO];
   assign blanking = passMode ? !passthrough_blank_in : !blank_n;

   // host port
   always_comb begin
      next_generalControl = generalControl;
      next_muxControl     = muxControl;
      next_dataOe         = !hostCtl.rdStrobe_n;
      next_dataOut        = dataOut;
      next_writeStrobe    = 1'b0;
      next_dacData        = dacData;
      if (rdPrev && !hostCtl.rdStrobe_n) begin
         if (hostCtl.register_select_bus == palette_port_pkg::SEL_HOLD) begin
            // six-bit reads mask the two msbs
            next_dataOut = hostCtl.wideMode ? holdValue
                         : {2'b00, holdValue[5:0]};
         end else if (hostCtl.register_select_bus == palette_port_pkg::SEL_GENCTRL) begin
            next_dataOut = generalControl;
         end else if (hostCtl.register_select_bus == palette_port_pkg::SEL_MUXCTRL) begin
            next_dataOut = muxControl;
         end else begin
            next_dataOut = 8'h00;
         end
      end
      if (!wrPrev && hostCtl.wrStrobe_n) begin
         next_writeStrobe = 1'b1;
         if (hostCtl.register_select_bus == palette_port_pkg::SEL_HOLD) begin
            next_dacData = toDac(dataIn, hostCtl.wideMode);
         end else if (hostCtl.register_select_bus == palette_port_pkg::SEL_GENCTRL) begin
            next_generalControl = dataIn;
         end else if (hostCtl.register_select_bus == palette_port_pkg::SEL_MUXCTRL) begin
            next_muxControl = dataIn;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         generalControl <= palette_port_pkg::GENCTRL_RST;
         muxControl     <= palette_port_pkg::MUXCTRL_RST;
         rdPrev         <= 1'b1;
         wrPrev         <= 1'b1;
         dataOe         <= 1'b0;
         dataOut        <= 8'h00;
         writeStrobe    <= 1'b0;
         dacData        <= 8'h00;
      end else begin
         generalControl <= next_generalControl;
         muxControl     <= next_muxControl;
         rdPrev         <= hostCtl.rdStrobe_n;
         wrPrev         <= hostCtl.wrStrobe_n;
         dataOe         <= next_dataOe;
         dataOut        <= next_dataOut;
         writeStrobe    <= next_writeStrobe;
         dacData        <= next_dacData;
      end
   end

   // clocks, flag and pixels
   palette_port_pkg::sclk_state_type scState, next_scState;
   logic [DIV_W-1:0] scCount, next_scCount, vcCount, next_vcCount;
   logic next_shiftClock, next_video_clock_out, flagPrev, nibbleHigh, next_nibbleHigh;
   logic next_mux_mode_indicator;
   logic [7:0] next_pixelOut;
   logic flagRise;

   assign flagRise = split_nibble_flag_in && !flagPrev;

   always_comb begin
      next_scState = scState;
      next_scCount = scCount;
      next_shiftClock = shiftClock;
      // video clock: half period of vclkDivisor mclk cycles
      next_vcCount = vcCount + DIV_W'(1);
      next_video_clock_out = video_clock_out;
      if (vcCount + DIV_W'(1) >= vclkDivisor) begin
         next_vcCount = '0;
         next_video_clock_out = !video_clock_out;
      end
      case (scState)
         palette_port_pkg::SC_IDLE: begin
            next_shiftClock = 1'b0;
            next_scCount = '0;
            if (blanking && splitEn && flagRise) begin
               next_scState = palette_port_pkg::SC_EXTRA;
            end else if (!blanking) begin
               next_scState = palette_port_pkg::SC_RUN;
            end
         end
         palette_port_pkg::SC_RUN: begin
            next_scCount = scCount + DIV_W'(1);
            if (scCount + DIV_W'(1) >= sclkDivisor) begin
               next_scCount = '0;
               next_shiftClock = !shiftClock;
            end
            if (blanking) begin
               next_shiftClock = 1'b0;
               next_scState = palette_port_pkg::SC_IDLE;
            end
         end
         palette_port_pkg::SC_EXTRA: begin
            // one full high-then-low shift clock cycle
            next_scCount = scCount + DIV_W'(1);
            if (scCount + DIV_W'(1) >= sclkDivisor) begin
               next_scCount = '0;
               next_shiftClock = !shiftClock;
               if (shiftClock) begin
                  next_scState = palette_port_pkg::SC_IDLE;
               end
            end
         end
         default: next_scState = palette_port_pkg::SC_IDLE;
      endcase
      // edges taken from next values above, so no loop through a separate net
      next_nibbleHigh = (nibbleEn && video_clock_out && !next_video_clock_out)
                      ? split_nibble_flag_in : nibbleHigh;
      next_pixelOut = pixelOut;
      if (passMode) begin
         next_pixelOut = passBus;
      end else if (!shiftClock && next_shiftClock) begin
         if (nibbleEn) begin
            next_pixelOut = nibbleHigh ? {4'h0, pixelBus[7:4]}
                          : {4'h0, pixelBus[3:0]};
         end else begin
            next_pixelOut = pixelBus;
         end
      end
      next_mux_mode_indicator = !passMode;
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         scState            <= palette_port_pkg::SC_IDLE;
         scCount            <= '0;
         vcCount            <= '0;
         shiftClock         <= 1'b0;
         video_clock_out    <= 1'b0;
         flagPrev           <= 1'b0;
         nibbleHigh         <= 1'b0;
         pixelOut           <= 8'h00;
         mux_mode_indicator <= 1'b1;
      end else begin
         scState            <= next_scState;
         scCount            <= next_scCount;
         vcCount            <= next_vcCount;
         shiftClock         <= next_shiftClock;
         video_clock_out    <= next_video_clock_out;
         flagPrev           <= split_nibble_flag_in;
         nibbleHigh         <= next_nibbleHigh;
         pixelOut           <= next_pixelOut;
         mux_mode_indicator <= next_mux_mode_indicator;
      end
   end

   property p_rd_drives;
      @(posedge mclk) disable iff (!arst_n)
         $fell(hostCtl.rdStrobe_n) |=> dataOe;
   endproperty
   a_rd_drives: assert property (p_rd_drives) else $error("read not driven");
   property p_wr_rise;
      @(posedge mclk) disable iff (!arst_n)
         $rose(hostCtl.wrStrobe_n) |=> writeStrobe;
   endproperty
   a_wr_rise: assert property (p_wr_rise) else $error("write not captured");
   property p_blank_off;
      @(posedge mclk) disable iff (!arst_n)
         (blanking && scState == palette_port_pkg::SC_RUN) |=> !shiftClock;
   endproperty
   a_blank_off: assert property (p_blank_off) else $error("sclk during blank");
   property p_mux_ind;
      @(posedge mclk) disable iff (!arst_n) passMode |=> !mux_mode_indicator;
   endproperty
   a_mux_ind: assert property (p_mux_ind) else $error("indicator high in pass mode");
   property p_pass;
      @(posedge mclk) disable iff (!arst_n) passMode |=> pixelOut == $past(passBus);
   endproperty
   a_pass: assert property (p_pass) else $error("pass bus not used");
   property p_extra;
      @(posedge mclk) disable iff (!arst_n)
         (scState == palette_port_pkg::SC_IDLE && blanking && splitEn && flagRise)
         |=> scState == palette_port_pkg::SC_EXTRA;
   endproperty
   a_extra: assert property (p_extra) else $error("no extra sclk");
   property p_low_dac;
      @(posedge mclk) disable iff (!arst_n)
         (writeStrobe && dacData != $past(dacData) && !$past(hostCtl.wideMode))
         |-> dacData[1:0] == 2'b00;
   endproperty
   a_low_dac: assert property (p_low_dac) else $error("low bits not zero");
   property p_low_read;
      @(posedge mclk) disable iff (!arst_n)
         ($fell(hostCtl.rdStrobe_n) && !hostCtl.wideMode
          && hostCtl.register_select_bus == palette_port_pkg::SEL_HOLD)
         |=> dataOut[7:6] == 2'b00;
   endproperty
   a_low_read: assert property (p_low_read) else $error("msbs not masked");
endmodule

// ### verification/palette_host_model.sv
// Purpose: host processor model driving the strobe port
// Assumes: requests launched 2 ns after mclk rise, held over sampling edges
// Notes:   data lines show inverted last value once released
module palette_host_model (
   input  wire logic                           mclk,
   output      palette_port_pkg::host_ctl_type hostCtl,
   output      logic [7:0]                     dataIn,
   input  wire logic [7:0]                     dataOut,
   input  wire logic                           dataOe
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      hostCtl = '{1'b1, 1'b1, 4'h0, 1'b1};
      dataIn = 8'h00;
   end
   task automatic setWide(input logic w);
      @(posedge mclk);
      #2;
      hostCtl.wideMode = w;
   endtask
   task automatic wr(input logic [3:0] sel, input logic [7:0] d);
      @(posedge mclk);
      #2;
      hostCtl.register_select_bus = sel;
      dataIn = d;
      hostCtl.wrStrobe_n = 1'b0;
      repeat (2) @(posedge mclk);
      #2;
      hostCtl.wrStrobe_n = 1'b1; // select held past the rise
      repeat (2) @(posedge mclk);
      #2;
      dataIn = ~d;
   endtask
   task automatic rd(input logic [3:0] sel, output logic [7:0] d, output logic oe);
      @(posedge mclk);
      #2;
      hostCtl.register_select_bus = sel;
      hostCtl.rdStrobe_n = 1'b0;
      repeat (2) @(posedge mclk);
      #2;
      d = dataOut;
      oe = dataOe;
      hostCtl.rdStrobe_n = 1'b1; // never overlaps a write
      repeat (2) @(posedge mclk);
   endtask
endmodule

// ### verification/palette_host_port_shift_clock_tb.sv
// Purpose: self-checking bench for host port and shift clock control
// Assumes: 40 MHz mclk, inputs driven 2 ns after the rising edge
// Notes:   clock rates checked with one edge of slack for window phase
module palette_host_port_shift_clock_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk, arst_n, dataOe, writeStrobe, shiftClock, video_clock_out;
   logic mux_mode_indicator, blank_n, passthrough_blank_in, split_nibble_flag_in, oe;
   palette_port_pkg::host_ctl_type hostCtl;
   logic [7:0] dataIn, dataOut, dacData, holdValue, pixelBus, passBus, pixelOut;
   logic [7:0] generalControl, sclkDivisor, vclkDivisor, d;
   int failures = 0, checked = 0, cycles = 0, wsCount = 0, s, v;
   logic [7:0] ctl [4] = '{8'h04, 8'h00, 8'hF3, 8'h08}; // bits 3 and 2 never both set
   palette_host_port_shift_clock #(.DIV_W(8)) dut (.mclk(mclk), .arst_n(arst_n),
      .hostCtl(hostCtl), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
      .writeStrobe(writeStrobe), .dacData(dacData), .holdValue(holdValue),
      .sclkDivisor(sclkDivisor), .vclkDivisor(vclkDivisor), .blank_n(blank_n),
      .passthrough_blank_in(passthrough_blank_in),
      .split_nibble_flag_in(split_nibble_flag_in), .pixelBus(pixelBus), .passBus(passBus),
      .shiftClock(shiftClock), .video_clock_out(video_clock_out),
      .mux_mode_indicator(mux_mode_indicator), .pixelOut(pixelOut),
      .generalControl(generalControl));
   palette_host_model host (.mclk(mclk), .hostCtl(hostCtl), .dataIn(dataIn),
      .dataOut(dataOut), .dataOe(dataOe));
   initial mclk = 1'b0;
   always #12.5 mclk = ~mclk;
   task automatic end_sim();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (writeStrobe === 1'b1) wsCount++;
      if (cycles == 5000) begin
         failures++;
         end_sim();
      end
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask
   // counts rising edges of both generated clocks over n cycles
   task automatic cnt(input int n, output int s, output int v);
      logic ps, pv;
      s = 0;
      v = 0;
      ps = shiftClock;
      pv = video_clock_out;
      repeat (n) begin
         step(1);
         if (shiftClock === 1'b1 && ps === 1'b0) s++;
         if (video_clock_out === 1'b1 && pv === 1'b0) v++;
         ps = shiftClock;
         pv = video_clock_out;
      end
   endtask
   initial begin
      {arst_n, blank_n, passthrough_blank_in, split_nibble_flag_in} = 4'b0110;
      {holdValue, pixelBus, passBus} = '0;
      sclkDivisor = 8'h02;
      vclkDivisor = 8'h03;
      step(4);
      arst_n = 1'b1;
      chk("genctl_rst", 8'h00, generalControl);
      chk("ind_rst", 8'h01, {7'h0, mux_mode_indicator});
      host.wr(palette_port_pkg::SEL_GENCTRL, 8'h04);
      chk("genctl", 8'h04, generalControl);
      chk("wstrobe", 8'h01, 8'(wsCount));
      holdValue = 8'hC5;
      host.rd(palette_port_pkg::SEL_HOLD, d, oe);
      chk("rd8", 8'hC5, d);
      chk("oe", 8'h01, {7'h0, oe});
      host.setWide(1'b0);
      host.rd(palette_port_pkg::SEL_HOLD, d, oe);
      chk("rd6", 8'h05, d);
      host.rd(4'h4, d, oe);
      chk("rd_unmapped", 8'h00, d);
      host.wr(palette_port_pkg::SEL_HOLD, 8'hFF);
      chk("dac6a", 8'hFC, dacData);
      host.wr(palette_port_pkg::SEL_HOLD, 8'h25);
      chk("dac6b", 8'h94, dacData);
      host.setWide(1'b1);
      host.wr(palette_port_pkg::SEL_HOLD, 8'hA5);
      chk("dac8", 8'hA5, dacData);
      cnt(60, s, v);
      chk("sclk_rate", 8'h01, {7'h0, s >= 14 && s <= 16});
      chk("video_clock_out_rate", 8'h01, {7'h0, v >= 9 && v <= 11});
      blank_n = 1'b0;
      step(2);
      cnt(20, s, v);
      chk("sclk_blank", 8'h00, 8'(s));
      for (int i = 0; i < 4; i++) begin
         host.wr(palette_port_pkg::SEL_GENCTRL, ctl[i]);
         step(2);
         split_nibble_flag_in = 1'b1;
         cnt(20, s, v);
         chk("split_extra", (i == 0) ? 8'h01 : 8'h00, 8'(s));
         split_nibble_flag_in = 1'b0;
      end
      blank_n = 1'b1;
      {sclkDivisor, vclkDivisor, pixelBus, split_nibble_flag_in} = {16'h0101, 8'hA3, 1'b1};
      step(10);
      chk("nib_hi", 8'h0A, pixelOut);
      split_nibble_flag_in = 1'b0;
      step(10);
      chk("nib_lo", 8'h03, pixelOut);
      passBus = 8'h5A;
      host.wr(palette_port_pkg::SEL_MUXCTRL, palette_port_pkg::MUX_PASSTHRU);
      step(2);
      chk("ind_pass", 8'h00, {7'h0, mux_mode_indicator});
      chk("pass_pix", 8'h5A, pixelOut);
      {passthrough_blank_in, passBus} = {1'b0, 8'hC3};
      step(2);
      chk("pass_pix2", 8'hC3, pixelOut);
      cnt(20, s, v);
      chk("pass_blank", 8'h00, 8'(s));
      {passthrough_blank_in, blank_n} = 2'b10;
      step(2);
      cnt(20, s, v);
      chk("pass_noblank", 8'h01, {7'h0, s > 0});
      host.wr(palette_port_pkg::SEL_MUXCTRL, 8'h00);
      step(2);
      chk("ind_norm", 8'h01, {7'h0, mux_mode_indicator});
      cnt(20, s, v);
      chk("norm_blank", 8'h00, 8'(s));
      end_sim();
   end
endmodule
